// file: include/spch_cfg.svh
// register offsets, field positions, codes and timing of the sensor parameter command handler
// assumes a 100 MHz pclk and byte addresses on an 8-bit APB address
`ifndef SPCH_CFG_SVH
`define SPCH_CFG_SVH

`define SPCH_OFF_CMD        8'h00
`define SPCH_OFF_LEN        8'h04
`define SPCH_OFF_DIN0       8'h08
`define SPCH_OFF_CTRL       8'h18
`define SPCH_OFF_STATUS     8'h1c
`define SPCH_OFF_RESP0      8'h20
`define SPCH_OFF_ERR        8'h30
`define SPCH_WIN_BYTES      8'h10

`define SPCH_CTRL_START     0
`define SPCH_CTRL_BOOT      1
`define SPCH_ST_BUSY        0
`define SPCH_ST_DONE        1
`define SPCH_ST_RLEN_LSB    8
`define SPCH_ST_RLEN_MSB    12
`define SPCH_DIR_BIT        7

`define SPCH_CMD_SET        16'h0100
`define SPCH_CMD_GET        16'h0200
`define SPCH_PAGE_VCFG      8'h05
`define SPCH_PAGE_PCTL      8'h0e
`define SPCH_VS_MIN         8'h01
`define SPCH_VS_MAX         8'h95

`define SPCH_VCFG_LEN       16'h000c
`define SPCH_ERR_STATUS     16'h000f
`define SPCH_ERR_LEN        16'h0004
`define SPCH_RLEN_ERR       5'h08
`define SPCH_RLEN_VCFG      5'h10
`define SPCH_RLEN_HDR       5'h05

`define SPCH_E_LENGTH       8'h01
`define SPCH_E_TOOLONG      8'h02
`define SPCH_E_PWRITE       8'h03
`define SPCH_E_PREAD        8'h04
`define SPCH_E_INVCMD       8'h05
`define SPCH_E_INVPAR       8'h06
`define SPCH_E_FAILED       8'hff
`define SPCH_EV_CMD         8'hc0
`define SPCH_EV_TOOLONG     8'hc1

`define SPCH_BUF_BOOT       16'h0080
`define SPCH_BUF_MAIN       16'h0400
`define SPCH_DIN_BYTES      16'h0010
`define SPCH_RD_MAX         4'hb

`define SPCH_TIMEOUT_NS     10000
`define SPCH_CLK_MHZ        100
`define SPCH_TIMEOUT_CYC    ((`SPCH_TIMEOUT_NS * `SPCH_CLK_MHZ) / 1000)

`endif

// file: include/spch_pkg.sv
// types shared by the sensor parameter command handler
// assumes spch_cfg.svh for all numeric constants
package spch_pkg;

  typedef enum logic [1:0] {
    SPCH_S_IDLE = 2'b00,
    SPCH_S_EXEC = 2'b01,
    SPCH_S_WAIT = 2'b11,
    SPCH_S_DONE = 2'b10
  } spch_state_t;

  typedef enum logic [2:0] {
    SPCH_K_ERR    = 3'h0,
    SPCH_K_VCFG   = 3'h1,
    SPCH_K_PSET_W = 3'h2,
    SPCH_K_PSET_R = 3'h3,
    SPCH_K_PGET   = 3'h4
  } spch_kind_t;

endpackage

// file: core/spch_word_reg.sv
// one software-written data word with write enable
// assumes a single pclk domain and asynchronous active-low reset
`timescale 1ns/1ps
module spch_word_reg #(
  parameter int unsigned W = 32
) (
  input  logic         pclk,
  input  logic         presetn,
  input  logic         we,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (we) begin
      q <= d;
    end
  end

endmodule

// file: core/spch_cmd_classify.sv
// decides what a latched host command is: error code or kind of work
// assumes inputs are stable flops while the handler executes
`timescale 1ns/1ps
`include "spch_cfg.svh"
module spch_cmd_classify (
  input  logic [15:0]         cmd_id,
  input  logic [15:0]         param,
  input  logic [15:0]         len,
  input  logic                boot_mode,
  input  logic [7:0]          code_byte,
  input  logic                pend_valid,
  input  logic [7:0]          pend_sensor,
  output spch_pkg::spch_kind_t kind,
  output logic [7:0]          err_code,
  output logic [15:0]         buf_limit
);
  import spch_pkg::*;

  logic [7:0] page;
  logic [7:0] low;
  assign page      = param[15:8];
  assign low       = param[7:0];
  assign buf_limit = boot_mode ? `SPCH_BUF_BOOT : `SPCH_BUF_MAIN;

  always_comb begin
    kind     = SPCH_K_ERR;
    err_code = `SPCH_E_INVCMD;
    if (cmd_id != `SPCH_CMD_SET && cmd_id != `SPCH_CMD_GET) begin
      err_code = `SPCH_E_INVCMD;
    end else if (len > buf_limit) begin
      err_code = `SPCH_E_TOOLONG;
    end else if (cmd_id == `SPCH_CMD_GET) begin
      if (len != 16'h0000) begin
        err_code = `SPCH_E_LENGTH;
      end else if (page == `SPCH_PAGE_VCFG && low >= `SPCH_VS_MIN && low <= `SPCH_VS_MAX) begin
        kind = SPCH_K_VCFG;
      end else if (page == `SPCH_PAGE_PCTL && pend_valid && pend_sensor == low) begin
        kind = SPCH_K_PGET;
      end else begin
        err_code = `SPCH_E_PREAD;
      end
    end else if (len[1:0] != 2'b00) begin
      err_code = `SPCH_E_LENGTH;
    end else if (len == 16'h0000 || page != `SPCH_PAGE_PCTL) begin
      err_code = `SPCH_E_PWRITE;
    end else if (len > `SPCH_DIN_BYTES) begin
      err_code = `SPCH_E_LENGTH;
    end else begin
      kind = code_byte[`SPCH_DIR_BIT] ? SPCH_K_PSET_R : SPCH_K_PSET_W;
    end
  end

endmodule

// file: core/spch_cmd_handler.sv
// sensor parameter command handler: APB command window, response window, driver handler ports
// assumes zero-wait APB master, and driver handlers that ack within the timeout
//
// Function
// - pages 0x05 ids 0x01-0x95 read-only configs
// - unsupported virtual sensor returns all-zero fields
// - fields unsigned, least significant byte first
// - configuration length field equals twelve
// - bytes four-seven carry float output rate
// - latency bytes eight-eleven, zero unless batching
// - range in bytes 14-15, 12-13 reserved
// - page 0x0e selects physical sensor control
// - code byte: bits 0-6 code, bit 7 direction
// - first control byte is the type code
// - direction clear: pass to write handler
// - direction set: remember code for next get
// - get length counts echoed code byte too
// - error response 0x000F, length 4, id, code
// - error value 0xC0/0xC1 loads aux and debug
// - command error code values 0x01-0x06, 0xFF
// - read error: oversize or invalid parameter
// - too long above 128 boot, 1024 main
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "spch_cfg.svh"
module spch_cmd_handler (
  input  logic         pclk,
  input  logic         presetn,
  input  logic         psel,
  input  logic         penable,
  input  logic         pwrite,
  input  logic [7:0]   paddr,
  input  logic [31:0]  pwdata,
  output logic [31:0]  prdata,
  output logic         pready,
  output logic         pslverr,
  output logic [7:0]   vcfg_sensor,
  input  logic         vcfg_supported,
  input  logic [31:0]  vcfg_rate,
  input  logic [31:0]  vcfg_latency,
  input  logic         vcfg_batch,
  input  logic [15:0]  vcfg_range,
  output logic [7:0]   drv_sensor,
  output logic [7:0]   drv_code,
  output logic         drv_wr_req,
  output logic [119:0] drv_wr_data,
  output logic [4:0]   drv_wr_len,
  input  logic         drv_wr_ack,
  input  logic         drv_wr_fail,
  output logic         drv_rd_req,
  input  logic         drv_rd_ack,
  input  logic         drv_rd_fail,
  input  logic [3:0]   drv_rd_len,
  input  logic [87:0]  drv_rd_data,
  output logic         busy
);
  import spch_pkg::*;
  localparam logic [9:0] TIMER_LAST = 10'(`SPCH_TIMEOUT_CYC - 1);
  default clocking cb_pclk @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  spch_state_t state_q, state_d;
  spch_kind_t  kind_q, kind_d, cls_kind;
  logic [15:0] cmd_q, param_q, len_q, buf_limit;
  logic [31:0] din_q [4];
  logic [31:0] resp_q [4], resp_d [4];
  logic [4:0]  rlen_q, rlen_d;
  logic [7:0]  errval_q, errval_d, aux_q, aux_d, dbg_q, dbg_d;
  logic [7:0]  cls_err, err_now_code, code_q, code_d;
  logic        err_now, boot_q, done_q, done_set;
  logic        pend_valid_q, pend_valid_d;
  logic [7:0]  pend_sensor_q, pend_sensor_d, pend_code_q, pend_code_d;
  logic        wr_req_q, wr_req_d, rd_req_q, rd_req_d;
  logic [9:0]  timer_q, timer_d;
  logic [31:0] prdata_q, rdata_mux;
  logic [87:0] rd_mask, rd_clean;

  wire         apb_setup  = psel & ~penable;
  wire         apb_wr     = psel & penable & pwrite;
  wire         aligned    = paddr[1:0] == 2'b00;
  wire [7:0]   din_off    = paddr - `SPCH_OFF_DIN0;
  wire [7:0]   resp_off   = paddr - `SPCH_OFF_RESP0;
  wire         hit_cmd    = aligned && paddr == `SPCH_OFF_CMD;
  wire         hit_len    = aligned && paddr == `SPCH_OFF_LEN;
  wire         hit_din    = aligned && paddr >= `SPCH_OFF_DIN0 && din_off < `SPCH_WIN_BYTES;
  wire         hit_ctrl   = aligned && paddr == `SPCH_OFF_CTRL;
  wire         hit_sts    = aligned && paddr == `SPCH_OFF_STATUS;
  wire         hit_resp   = aligned && paddr >= `SPCH_OFF_RESP0 && resp_off < `SPCH_WIN_BYTES;
  wire         hit_err    = aligned && paddr == `SPCH_OFF_ERR;
  wire         mapped     = hit_cmd | hit_len | hit_din | hit_ctrl | hit_sts | hit_resp | hit_err;
  wire         idle       = state_q == SPCH_S_IDLE;
  // command inputs frozen while busy so the handler never sees a torn command
  wire         wr_cmd     = apb_wr & hit_cmd & idle;
  wire         wr_len     = apb_wr & hit_len & idle;
  wire         wr_ctrl    = apb_wr & hit_ctrl;
  wire         start      = wr_ctrl & idle & pwdata[`SPCH_CTRL_START];
  wire         done_clr   = apb_wr & hit_sts & pwdata[`SPCH_ST_DONE];
  wire [31:0]  sts_word   = {19'h00000, rlen_q, 6'h00, done_q, busy};
  wire [31:0]  ctrl_word  = {30'h00000000, boot_q, 1'b0};
  wire [31:0]  err_word   = {8'h00, dbg_q, aux_q, errval_q};

  assign rdata_mux = hit_cmd  ? {param_q, cmd_q} :
                     hit_len  ? {16'h0000, len_q} :
                     hit_din  ? din_q[din_off[3:2]] :
                     hit_ctrl ? ctrl_word :
                     hit_sts  ? sts_word :
                     hit_resp ? resp_q[resp_off[3:2]] :
                     hit_err  ? err_word : 32'h00000000;

  assign pready      = 1'b1;
  assign pslverr     = psel & penable & ~mapped;
  assign prdata      = prdata_q;
  assign busy        = ~idle;
  assign vcfg_sensor = param_q[7:0];
  assign drv_sensor  = param_q[7:0];
  assign drv_code    = code_q;
  assign drv_wr_req  = wr_req_q;
  assign drv_rd_req  = rd_req_q;
  assign drv_wr_data = {din_q[3], din_q[2], din_q[1], din_q[0][31:8]};
  assign drv_wr_len  = len_q[4:0];
  // bytes past the driver's stated length are forced to zero
  assign rd_mask     = ~({88{1'b1}} << {drv_rd_len, 3'b000});
  assign rd_clean    = drv_rd_data & rd_mask;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_din
      spch_word_reg #(.W(32)) u_din (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (apb_wr & hit_din & idle & (din_off[3:2] == 2'(gi))),
        .d       (pwdata),
        .q       (din_q[gi])
      );
    end
  endgenerate

  spch_cmd_classify u_cls (
    .cmd_id      (cmd_q),
    .param       (param_q),
    .len         (len_q),
    .boot_mode   (boot_q),
    .code_byte   (din_q[0][7:0]),
    .pend_valid  (pend_valid_q),
    .pend_sensor (pend_sensor_q),
    .kind        (cls_kind),
    .err_code    (cls_err),
    .buf_limit   (buf_limit)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q    <= 16'h0000;
      param_q  <= 16'h0000;
      len_q    <= 16'h0000;
      boot_q   <= 1'b0;
      done_q   <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      if (wr_cmd) begin
        cmd_q   <= pwdata[15:0];
        param_q <= pwdata[31:16];
      end
      if (wr_len) len_q <= pwdata[15:0];
      if (wr_ctrl) boot_q <= pwdata[`SPCH_CTRL_BOOT];
      done_q <= done_set | (done_q & ~done_clr);
      if (apb_setup & ~pwrite) prdata_q <= rdata_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_comb begin
    state_d       = state_q;
    kind_d        = kind_q;
    resp_d        = resp_q;
    rlen_d        = rlen_q;
    errval_d      = errval_q;
    aux_d         = aux_q;
    dbg_d         = dbg_q;
    code_d        = code_q;
    pend_valid_d  = pend_valid_q;
    pend_sensor_d = pend_sensor_q;
    pend_code_d   = pend_code_q;
    wr_req_d      = 1'b0;
    rd_req_d      = 1'b0;
    timer_d       = timer_q;
    done_set      = 1'b0;
    err_now       = 1'b0;
    err_now_code  = cls_err;
    case (state_q)
      SPCH_S_IDLE: state_d = start ? SPCH_S_EXEC : SPCH_S_IDLE;
      SPCH_S_EXEC: begin
        kind_d  = cls_kind;
        timer_d = 10'h000;
        state_d = SPCH_S_DONE;
        case (cls_kind)
          SPCH_K_VCFG: begin
            resp_d[0] = {`SPCH_VCFG_LEN, param_q};
            resp_d[1] = vcfg_supported ? vcfg_rate : 32'h00000000;
            resp_d[2] = (vcfg_supported && vcfg_batch) ? vcfg_latency : 32'h00000000;
            resp_d[3] = {vcfg_supported ? vcfg_range : 16'h0000, 16'h0000};
            rlen_d    = `SPCH_RLEN_VCFG;
          end
          SPCH_K_PSET_W: begin
            code_d   = din_q[0][7:0];
            wr_req_d = 1'b1;
            state_d  = SPCH_S_WAIT;
          end
          SPCH_K_PSET_R: begin
            // one pending slot: a later read set replaces an unserved one
            pend_valid_d  = 1'b1;
            pend_sensor_d = param_q[7:0];
            pend_code_d   = din_q[0][7:0];
            rlen_d        = 5'h00;
          end
          SPCH_K_PGET: begin
            code_d       = pend_code_q;
            rd_req_d     = 1'b1;
            pend_valid_d = 1'b0;
            state_d      = SPCH_S_WAIT;
          end
          default: err_now = 1'b1;
        endcase
      end
      SPCH_S_WAIT: begin
        timer_d = timer_q + 10'h001;
        if (kind_q == SPCH_K_PSET_W && drv_wr_ack) begin
          state_d      = SPCH_S_DONE;
          err_now      = drv_wr_fail;
          err_now_code = `SPCH_E_PWRITE;
          rlen_d       = 5'h00;
        end else if (kind_q == SPCH_K_PGET && drv_rd_ack) begin
          state_d = SPCH_S_DONE;
          if (drv_rd_fail || drv_rd_len > `SPCH_RD_MAX) begin
            err_now      = 1'b1;
            err_now_code = `SPCH_E_PREAD;
          end else begin
            resp_d[0] = {12'h000, drv_rd_len + 4'h1, param_q};
            resp_d[1] = {rd_clean[23:0], code_q};
            resp_d[2] = rd_clean[55:24];
            resp_d[3] = rd_clean[87:56];
            rlen_d    = `SPCH_RLEN_HDR + 5'(drv_rd_len);
          end
        end else if (timer_q == TIMER_LAST) begin
          state_d      = SPCH_S_DONE;
          err_now      = 1'b1;
          err_now_code = `SPCH_E_FAILED;
        end
      end
      SPCH_S_DONE: begin
        done_set = 1'b1;
        state_d  = SPCH_S_IDLE;
      end
      default: state_d = SPCH_S_IDLE;
    endcase
    if (err_now) begin
      resp_d[0] = {`SPCH_ERR_LEN, `SPCH_ERR_STATUS};
      resp_d[1] = {8'h00, err_now_code, cmd_q};
      resp_d[2] = 32'h00000000;
      resp_d[3] = 32'h00000000;
      rlen_d    = `SPCH_RLEN_ERR;
      errval_d  = (err_now_code == `SPCH_E_TOOLONG) ? `SPCH_EV_TOOLONG : `SPCH_EV_CMD;
      aux_d     = err_now_code;
      dbg_d     = cmd_q[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q       <= SPCH_S_IDLE;
      kind_q        <= SPCH_K_ERR;
      resp_q        <= '{default: 32'h00000000};
      rlen_q        <= 5'h00;
      errval_q      <= 8'h00;
      aux_q         <= 8'h00;
      dbg_q         <= 8'h00;
      code_q        <= 8'h00;
      pend_valid_q  <= 1'b0;
      pend_sensor_q <= 8'h00;
      pend_code_q   <= 8'h00;
      wr_req_q      <= 1'b0;
      rd_req_q      <= 1'b0;
      timer_q       <= 10'h000;
    end else begin
      state_q       <= state_d;
      kind_q        <= kind_d;
      resp_q        <= resp_d;
      rlen_q        <= rlen_d;
      errval_q      <= errval_d;
      aux_q         <= aux_d;
      dbg_q         <= dbg_d;
      code_q        <= code_d;
      pend_valid_q  <= pend_valid_d;
      pend_sensor_q <= pend_sensor_d;
      pend_code_q   <= pend_code_d;
      wr_req_q      <= wr_req_d;
      rd_req_q      <= rd_req_d;
      timer_q       <= timer_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  wire exec_vcfg = state_q == SPCH_S_EXEC && cls_kind == SPCH_K_VCFG;
  wire exec_err  = state_q == SPCH_S_EXEC && cls_kind == SPCH_K_ERR;
  // own count of waiting cycles, so a broken timer compare still shows up
  logic [10:0] wait_cnt_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) wait_cnt_q <= 11'h000;
    else wait_cnt_q <= (state_q == SPCH_S_WAIT) ? wait_cnt_q + 11'h001 : 11'h000;

  property p_vcfg_len;
    exec_vcfg |=> resp_q[0][31:16] == `SPCH_VCFG_LEN && resp_q[0][15:0] == $past(param_q);
  endproperty
  a_vcfg_len: assert property (p_vcfg_len) else $error("config length or id wrong");
  property p_vcfg_zero;
    exec_vcfg && !vcfg_supported |=> resp_q[1] == 32'h0 && resp_q[2] == 32'h0 && resp_q[3] == 32'h0;
  endproperty
  a_vcfg_zero: assert property (p_vcfg_zero) else $error("unsupported sensor fields not zero");
  property p_vcfg_fields;
    exec_vcfg && vcfg_supported |=> resp_q[1] == $past(vcfg_rate) && resp_q[3][31:16] == $past(vcfg_range)
      && resp_q[3][15:0] == 16'h0 && (resp_q[2] == ($past(vcfg_batch) ? $past(vcfg_latency) : 32'h0));
  endproperty
  a_vcfg_fields: assert property (p_vcfg_fields) else $error("config fields misplaced");
  property p_err_resp;
    exec_err |=> resp_q[0] == {`SPCH_ERR_LEN, `SPCH_ERR_STATUS}
      && resp_q[1] == {8'h00, $past(cls_err), $past(cmd_q)} && rlen_q == `SPCH_RLEN_ERR;
  endproperty
  a_err_resp: assert property (p_err_resp) else $error("error response malformed");
  property p_err_aux;
    exec_err |=> aux_q == $past(cls_err) && dbg_q == $past(cmd_q[7:0]) && state_q == SPCH_S_DONE;
  endproperty
  a_err_aux: assert property (p_err_aux) else $error("aux or debug status not loaded");
  property p_toolong;
    state_q == SPCH_S_EXEC && (cmd_q == `SPCH_CMD_SET || cmd_q == `SPCH_CMD_GET) && len_q > buf_limit
      |=> errval_q == `SPCH_EV_TOOLONG && aux_q == `SPCH_E_TOOLONG;
  endproperty
  a_toolong: assert property (p_toolong) else $error("too long not flagged");
  property p_wr_pass;
    state_q == SPCH_S_EXEC && cls_kind == SPCH_K_PSET_W
      |=> drv_wr_req && !drv_code[`SPCH_DIR_BIT] && drv_code == $past(din_q[0][7:0]) ##1 !drv_wr_req;
  endproperty
  a_wr_pass: assert property (p_wr_pass) else $error("write handler not called once");
  property p_rd_code;
    state_q == SPCH_S_EXEC && cls_kind == SPCH_K_PGET
      |=> drv_rd_req && drv_code == $past(pend_code_q) && !pend_valid_q;
  endproperty
  a_rd_code: assert property (p_rd_code) else $error("read handler code not remembered one");
  property p_get_len;
    state_q == SPCH_S_WAIT && kind_q == SPCH_K_PGET && drv_rd_ack && !drv_rd_fail && drv_rd_len <= `SPCH_RD_MAX
      |=> resp_q[0][31:16] == 16'($past(drv_rd_len)) + 16'h0001 && resp_q[1][7:0] == $past(code_q);
  endproperty
  a_get_len: assert property (p_get_len) else $error("get length excludes code byte");
  property p_wait_bound;
    state_q == SPCH_S_WAIT |-> wait_cnt_q < 11'(`SPCH_TIMEOUT_CYC);
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("handler wait not bounded");

  c_vcfg: cover property (@(posedge pclk) disable iff (!presetn) exec_vcfg && vcfg_supported);
  c_err:  cover property (@(posedge pclk) disable iff (!presetn) exec_err ##2 done_q);
  c_get:  cover property (@(posedge pclk) disable iff (!presetn)
            state_q == SPCH_S_WAIT && kind_q == SPCH_K_PGET && drv_rd_ack && !drv_rd_fail);
  c_tout: cover property (@(posedge pclk) disable iff (!presetn) state_q == SPCH_S_WAIT && timer_q == TIMER_LAST);

endmodule

// file: bench/spch_drv_model.sv
// driver handlers and virtual sensor table on the far side of the handler
// assumes one pclk; acks are one-cycle pulses, no reset of its own
`timescale 1ns/1ps
module spch_drv_model (
  input  logic         pclk,
  input  logic [7:0]   vcfg_sensor,
  output logic         vcfg_supported,
  output logic [31:0]  vcfg_rate,
  output logic [31:0]  vcfg_latency,
  output logic         vcfg_batch,
  output logic [15:0]  vcfg_range,
  input  logic [7:0]   drv_code,
  input  logic         drv_wr_req,
  output logic         drv_wr_ack,
  output logic         drv_wr_fail,
  input  logic         drv_rd_req,
  output logic         drv_rd_ack,
  output logic         drv_rd_fail,
  output logic [3:0]   drv_rd_len,
  output logic [87:0]  drv_rd_data,
  output logic [7:0]   last_wr_code
);
  logic [2:0] rd_dly = 3'h0;
  // id 0x95 absent from this image; odd ids batch
  assign vcfg_supported = (vcfg_sensor != 8'h95);
  assign vcfg_rate      = {24'h42c800, vcfg_sensor};
  assign vcfg_latency   = 32'h00001388;
  assign vcfg_batch     = vcfg_sensor[0];
  assign vcfg_range     = {8'h10, vcfg_sensor};
  // code 0x7f is refused by the write handler and oversized by the read one; the write handler never acks 0x7e
  assign drv_wr_fail = drv_wr_ack && (drv_code[6:0] == 7'h7f);
  assign drv_rd_ack  = rd_dly[2];
  assign drv_rd_fail = 1'b0;
  // read data only valid with ack; toggles otherwise
  assign drv_rd_len  = !drv_rd_ack ? 4'hd : (drv_code[6:0] == 7'h7f) ? 4'hc : 4'h2;
  assign drv_rd_data = drv_rd_ack ? {72'h0, 8'hb2, 8'ha1} : {88{rd_dly[0]}};
  initial drv_wr_ack = 1'b0;
  always @(posedge pclk) begin
    drv_wr_ack <= drv_wr_req && (drv_code[6:0] != 7'h7e);
    rd_dly     <= {rd_dly[1:0], drv_rd_req};
    if (drv_wr_req) begin
      last_wr_code <= drv_code;
    end
  end
endmodule

// file: bench/tb_sensor_param_cmd_handler.sv
// self-checking bench for the sensor parameter command handler
// assumes the drive model beside it and zero-wait APB
`timescale 1ns/1ps
`include "spch_cfg.svh"
module tb_sensor_param_cmd_handler;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q, vs, vb, wa, wf, ra, rf, wq, rq, busy;
  logic [7:0] paddr, vsen, dsen, dcode, wcode;
  logic [31:0] pwdata, prdata, rd, st, vr, vl;
  logic [31:0] resp [4];
  logic [15:0] vrg;
  logic [3:0] rl;
  logic [4:0] wlen;
  logic [119:0] wdat;
  logic [87:0] rdd;
  int errors = 0;
  int tests_run = 0;
  spch_cmd_handler u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .vcfg_sensor(vsen),
    .vcfg_supported(vs), .vcfg_rate(vr), .vcfg_latency(vl), .vcfg_batch(vb), .vcfg_range(vrg),
    .drv_sensor(dsen), .drv_code(dcode), .drv_wr_req(wq), .drv_wr_data(wdat), .drv_wr_len(wlen),
    .drv_wr_ack(wa), .drv_wr_fail(wf), .drv_rd_req(rq), .drv_rd_ack(ra), .drv_rd_fail(rf), .drv_rd_len(rl),
    .drv_rd_data(rdd), .busy(busy));
  spch_drv_model u_model (.pclk(pclk), .vcfg_sensor(vsen), .vcfg_supported(vs), .vcfg_rate(vr),
    .vcfg_latency(vl), .vcfg_batch(vb), .vcfg_range(vrg), .drv_code(dcode), .drv_wr_req(wq),
    .drv_wr_ack(wa), .drv_wr_fail(wf), .drv_rd_req(rq), .drv_rd_ack(ra), .drv_rd_fail(rf),
    .drv_rd_len(rl), .drv_rd_data(rdd), .last_wr_code(wcode));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // entered right after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    err_q = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic run(input logic [15:0] c, p, l, input logic [31:0] d0, input logic b);
    apb(1'b1, `SPCH_OFF_STATUS, 32'h2, rd);
    apb(1'b1, `SPCH_OFF_CMD, {p, c}, rd);
    apb(1'b1, `SPCH_OFF_LEN, {16'h0, l}, rd);
    apb(1'b1, `SPCH_OFF_DIN0, d0, rd);
    apb(1'b1, `SPCH_OFF_CTRL, {30'h0, b, 1'b1}, rd);
    chk("busy", {31'h0, busy}, 32'h1);
    do begin
      apb(1'b0, `SPCH_OFF_STATUS, 32'h0, st);
    end while (st[1] !== 1'b1);
    chk("idle", {30'h0, busy, st[0]}, 32'h0);
    for (int i = 0; i < 4; i++) apb(1'b0, `SPCH_OFF_RESP0 + 8'(4 * i), 32'h0, resp[i]);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_vcfg;
    run(`SPCH_CMD_GET, 16'h0501, 16'h0, 32'h0, 1'b0);
    chk("vcfg hdr", resp[0], 32'h000c0501);
    chk("vcfg rate", resp[1], 32'h42c80001);
    chk("vcfg lat", resp[2], 32'h00001388);
    chk("vcfg range", resp[3], 32'h10010000);
    chk("vcfg count", 32'(st[12:8]), 32'h10);
    run(`SPCH_CMD_GET, 16'h0502, 16'h0, 32'h0, 1'b0);
    chk("vcfg nobatch", resp[2], 32'h0);
    run(`SPCH_CMD_GET, 16'h0595, 16'h0, 32'h0, 1'b0);
    chk("vcfg absent", resp[1] | resp[2] | resp[3], 32'h0);
  endtask
  task automatic t_err;
    logic [15:0] c [10] = '{16'h0300, 16'h0200, 16'h0200, 16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0100,
                            16'h0100, 16'h0200};
    logic [15:0] p [10] = '{16'h0501, 16'h0501, 16'h0596, 16'h0e03, 16'h0501, 16'h0e03, 16'h0e03, 16'h0e03,
                            16'h0e03, 16'h0e03};
    logic [15:0] l [10] = '{16'h0, 16'h4, 16'h0, 16'h6, 16'h4, 16'h84, 16'h80, 16'h404, 16'h4, 16'h0};
    logic [7:0] e [10] = '{8'h05, 8'h01, 8'h04, 8'h01, 8'h03, 8'h02, 8'h01, 8'h02, 8'h03, 8'h04};
    logic ev;
    for (int i = 0; i < 10; i++) begin
      run(c[i], p[i], l[i], 32'h7f, (i == 5 || i == 6));
      ev = (e[i] == 8'h02);
      chk("err hdr", resp[0], 32'h0004000f);
      chk("err body", resp[1], {8'h0, e[i], c[i]});
      chk("err tail", resp[2] | resp[3], 32'h0);
      chk("err count", 32'(st[12:8]), 32'h8);
      apb(1'b0, `SPCH_OFF_ERR, 32'h0, rd);
      chk("err regs", rd, {8'h0, c[i][7:0], e[i], 7'h60, ev});
    end
  endtask
  task automatic t_ctl;
    run(`SPCH_CMD_SET, 16'h0e03, 16'h4, 32'h00332212, 1'b0);
    chk("wr code", {24'h0, wcode}, 32'h12);
    chk("wr data", wdat[31:0], 32'h00003322);
    chk("wr len", {27'h0, wlen}, 32'h4);
    chk("wr sensor", {24'h0, dsen}, 32'h3);
    chk("set count", 32'(st[12:8]), 32'h0);
    run(`SPCH_CMD_SET, 16'h0e07, 16'h4, 32'h85, 1'b0);
    run(`SPCH_CMD_GET, 16'h0e07, 16'h0, 32'h0, 1'b0);
    chk("get hdr", resp[0], 32'h00030e07);
    chk("get data", resp[1], 32'h00b2a185);
    chk("get count", 32'(st[12:8]), 32'h7);
    run(`SPCH_CMD_GET, 16'h0e07, 16'h0, 32'h0, 1'b0);
    chk("get again", resp[1], 32'h00040200);
    run(`SPCH_CMD_SET, 16'h0e07, 16'h4, 32'hff, 1'b0);
    run(`SPCH_CMD_GET, 16'h0e07, 16'h0, 32'h0, 1'b0);
    chk("get big", resp[1], 32'h00040200);
    run(`SPCH_CMD_SET, 16'h0e03, 16'h4, 32'h7e, 1'b0);
    chk("timeout", resp[1], 32'h00ff0100);
    chk("ready", {31'h0, pready}, 32'h1);
    apb(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped", {err_q, rd[30:0]}, 32'h80000000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    results;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_vcfg;
    t_err;
    t_ctl;
    results;
  end
endmodule
